//--- design/ips_pkg.sv
// Shared constants and types of the interrupt and standby controller
package ips_pkg;
   localparam int unsigned NUM_VEC = 14;
   localparam int unsigned NUM_SRC = 61;
   localparam int unsigned EXT_PINS = 8;
   localparam int unsigned PERIPH_SRCS = 53;
   localparam int unsigned PERIPH_IN = 50;
   localparam int unsigned P0_BASE = 40;
   localparam int unsigned P0_SRCS = 3;
   localparam int unsigned P0_PINS = 6;
   localparam int unsigned STACK_BYTES = 6;
   localparam int unsigned DIV_SEL_W = 3;
   localparam int unsigned DIV_CNT_W = 7;
   localparam int unsigned VEC_IDX_W = 4;
   localparam int unsigned ADDR_W = 20;

   // Vector addresses, index order is arbitration order
   localparam logic [19:0] VEC_ADDR [NUM_VEC] = '{
      20'h0_8000, 20'h0_8004, 20'h0_8008, 20'h0_800C,
      20'h0_8014, 20'h0_8018, 20'h0_801C, 20'h0_8020,
      20'h0_8024, 20'h0_802C, 20'h0_8030, 20'h0_8034,
      20'h0_8038, 20'h0_803C};

   // First peripheral source of each vector
   localparam int unsigned VEC_FIRST [NUM_VEC+1] = '{
      0, 1, 3, 5, 5, 5, 11, 17, 23, 26, 28, 32, 37, 40, 53};

   // Vector served by each external pin
   localparam int unsigned EXT_VEC [EXT_PINS] = '{
      3, 4, 5, 6, 7, 8, 11, 12};

   // Standby release sources
   localparam logic [52:0] HOLD_WAKE_SRC = 53'h07_FFFE_C300_0780;
   localparam logic [52:0] CRYSTAL_HOLD_MODE_WAKE_SRC = 53'h0F_FFFE_C378_0786;
   localparam logic [7:0] EXT_WAKE = 8'hF7;

   typedef enum logic [1:0] {
      LVL_NONE, LVL_LOW, LVL_HIGH, LVL_TOP
   } ips_lvl_t;

   typedef enum logic [1:0] {
      MODE_RUN, MODE_HALT, MODE_HOLD, MODE_CRYSTAL_HOLD_MODE
   } ips_mode_t;

   typedef enum logic [2:0] {
      EXT_HIGH, EXT_LOW, EXT_RISE, EXT_FALL, EXT_BOTH
   } ips_ext_mode_t;
endpackage : ips_pkg

//--- design/ips_ext_det.sv
// External interrupt pin request detectors
`timescale 1ns/1ps
module ips_ext_det #(
   parameter int unsigned N = ips_pkg::EXT_PINS
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Pins and configuration
   input wire logic [N-1:0] i_pin,
   input wire ips_pkg::ips_ext_mode_t i_mode [N],
   input wire logic [N-1:0] i_clr,
   // Requests
   output logic [N-1:0] o_req
);
   import ips_pkg::*;

   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] flag;
   } ips_det_t;

   ips_det_t q, d;

   always_comb begin
      d = q;
      d.prev = i_pin;
      for (int p = 0; p < N; p++) begin
         unique case (i_mode[p])
            EXT_HIGH: d.flag[p] = i_pin[p];
            EXT_LOW: d.flag[p] = ~i_pin[p];
            EXT_RISE: d.flag[p] = (i_pin[p] & ~q.prev[p])
               | (q.flag[p] & ~i_clr[p]);
            EXT_FALL: d.flag[p] = (~i_pin[p] & q.prev[p])
               | (q.flag[p] & ~i_clr[p]);
            EXT_BOTH: d.flag[p] = (i_pin[p] ^ q.prev[p])
               | (q.flag[p] & ~i_clr[p]);
            default: d.flag[p] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_req = q.flag;
endmodule : ips_ext_det

//--- design/ips_clk_div.sv
// System clock divider, 1/1 to 1/128 enable pulse
`timescale 1ns/1ps
module ips_clk_div #(
   parameter int unsigned CW = ips_pkg::DIV_CNT_W
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Ratio select, division is two to the power sel
   input wire logic [ips_pkg::DIV_SEL_W-1:0] i_sel,
   // Divided clock enable
   output logic o_tick
);
   import ips_pkg::*;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } ips_div_t;

   ips_div_t q, d;
   logic [CW-1:0] mask;

   always_comb begin
      mask = CW'((8'h01 << i_sel) - 8'h01);
      d = q;
      d.tick = (q.cnt >= mask);
      d.cnt = d.tick ? '0 : q.cnt + 1'b1;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_tick = q.tick;
endmodule : ips_clk_div

//--- design/ips_ctrl_top.sv
// Interrupt priority, vectoring and standby control
//
// Summary of operation
// - Three nested levels, refuse equal or lower
// - Highest pending level is served first
// - Equal level: smallest vector address wins
// - Sixty-one sources merged onto fourteen vectors
// - Pin 2, timer 1, async B to 08018H
// - Pin 3, timer 2, two-wire units to 0801CH
// - Port 0, port 5, calendar, CRC to 0803CH
// - Halt stops CPU, interrupt or reset releases
// - Full hold stops CPU, peripherals, all oscillators
// - Six causes release full hold
// - Crystal hold keeps crystal as at entry
// - Crystal hold adds base, infrared, calendar causes
// - Clock divider from 1/1 to 1/128
// - Pins detect high, low, rise, fall, both
// - Only port 0 lower six pins interrupt
// - Vector call pushes six stack bytes
`timescale 1ns/1ps
module ips_ctrl_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,

   // External interrupt pins
   input wire logic [ips_pkg::EXT_PINS-1:0] i_ext_irq_pin,
   input wire ips_pkg::ips_ext_mode_t
      i_ext_mode [ips_pkg::EXT_PINS],
   input wire logic [ips_pkg::EXT_PINS-1:0] i_ext_clr,

   // Port 0 lower pins and their enables
   input wire logic [ips_pkg::P0_PINS-1:0] i_port0_pin,
   input wire logic [ips_pkg::P0_PINS-1:0] i_port0_irq_en,

   // Peripheral requests, levels held by the peripheral
   input wire logic [ips_pkg::PERIPH_IN-1:0] i_periph_req,

   // Level of each vector, none masks it
   input wire ips_pkg::ips_lvl_t i_vec_level [ips_pkg::NUM_VEC],

   // CPU vectoring handshake
   input wire logic i_irq_ack,
   input wire logic i_irq_ret,
   output logic o_irq_req,
   output logic [ips_pkg::ADDR_W-1:0] o_irq_vec_addr,
   output ips_pkg::ips_lvl_t o_irq_level,
   output logic o_stack_push,
   output logic [3:0] o_stack_bytes,

   // Standby requests and oscillator settings
   input wire logic i_halt_req,
   input wire logic i_hold_req,
   input wire logic i_crystal_hold_mode_req,
   input wire logic i_main_osc_on,
   input wire logic i_rc_osc_on,
   input wire logic i_xtal_osc_on,

   // Standby outputs
   output ips_pkg::ips_mode_t o_mode,
   output logic o_cpu_run,
   output logic o_periph_run,
   output logic o_xtal_periph_run,
   output logic o_main_osc_en,
   output logic o_rc_osc_en,
   output logic o_xtal_osc_en,

   // Clock divider
   input wire logic [ips_pkg::DIV_SEL_W-1:0] i_clk_div_sel,
   output logic o_sys_clk_en,

   // Status
   output logic [ips_pkg::NUM_VEC-1:0] o_vec_pend,
   output ips_pkg::ips_lvl_t o_cur_level,
   output logic [1:0] o_nest_depth,
   output logic [ips_pkg::EXT_PINS-1:0] o_ext_req
);
   import ips_pkg::*;

   typedef struct packed {
      ips_lvl_t cur;
      logic [1:0] depth;
      logic [2:0][1:0] stack;
      logic irq_req;
      logic [ADDR_W-1:0] vec_addr;
      ips_lvl_t req_lvl;
      logic push;
      logic [3:0] push_bytes;
      ips_mode_t mode;
      logic xtal_keep;
      logic cpu_run;
      logic periph_run;
      logic xtal_periph_run;
      logic main_osc;
      logic rc_osc;
      logic xtal_osc;
      logic [NUM_VEC-1:0] pend;
   } ips_state_t;

   ips_state_t q, d;

   logic [EXT_PINS-1:0] ext_req;
   logic [P0_SRCS-1:0] p0_src;
   logic [PERIPH_SRCS-1:0] src;
   logic [NUM_VEC-1:0] vec_pend;
   logic wake_hold;
   logic wake_crystal_hold_mode;
   ips_lvl_t best_lvl;
   logic [VEC_IDX_W-1:0] best_idx;
   logic accept;
   logic ret;

   // Pin request detectors
   ips_ext_det #(
      .N(EXT_PINS)
   ) u_ext_det (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_pin(i_ext_irq_pin),
      .i_mode(i_ext_mode),
      .i_clr(i_ext_clr),
      .o_req(ext_req)
   );

   // Divided system clock enable
   ips_clk_div #(
      .CW(DIV_CNT_W)
   ) u_clk_div (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_sel(i_clk_div_sel),
      .o_tick(o_sys_clk_en)
   );

   // Port 0 sources from pin pairs of the lower six pins
   for (genvar k = 0; k < P0_SRCS; k++) begin : g_p0
      assign p0_src[k] = |(i_port0_pin[2*k+1:2*k]
         & i_port0_irq_en[2*k+1:2*k]);
   end

   assign src = {i_periph_req[PERIPH_IN-1:P0_BASE], p0_src,
      i_periph_req[P0_BASE-1:0]};

   // Collapse all sources of one vector into its request
   function automatic logic vec_hit(
      input int unsigned v,
      input logic [PERIPH_SRCS-1:0] s,
      input logic [EXT_PINS-1:0] e
   );
      logic hit;
      hit = 1'b0;
      for (int unsigned i = 0; i < PERIPH_SRCS; i++) begin
         if (i >= VEC_FIRST[v] && i < VEC_FIRST[v+1]) begin
            hit = hit | s[i];
         end
      end
      for (int unsigned p = 0; p < EXT_PINS; p++) begin
         if (EXT_VEC[p] == v) begin
            hit = hit | e[p];
         end
      end
      return hit;
   endfunction : vec_hit

   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      assign vec_pend[v] = vec_hit(v, src, ext_req);
   end

   // Standby release causes
   assign wake_hold = |(src & HOLD_WAKE_SRC)
      | |(ext_req & EXT_WAKE);
   assign wake_crystal_hold_mode = |(src & CRYSTAL_HOLD_MODE_WAKE_SRC)
      | |(ext_req & EXT_WAKE);

   // Level arbitration
   always_comb begin
      best_lvl = LVL_NONE;
      best_idx = '0;
      for (int v = 0; v < NUM_VEC; v++) begin
         // Strict compare keeps the smaller index on a tie
         if (vec_pend[v] && i_vec_level[v] > best_lvl) begin
            best_lvl = i_vec_level[v];
            best_idx = VEC_IDX_W'(v);
         end
      end
   end

   assign accept = i_irq_ack && q.irq_req && q.cpu_run;
   assign ret = i_irq_ret && !accept && (q.depth != 2'd0);

   always_comb begin
      d = q;
      d.push = 1'b0;
      d.pend = vec_pend;

      // Nesting of service levels
      if (accept) begin
         d.stack[q.depth] = q.cur;
         d.depth = q.depth + 2'd1;
         d.cur = q.req_lvl;
         d.push = 1'b1;
         d.push_bytes = 4'(STACK_BYTES);
      end else if (ret) begin
         d.depth = q.depth - 2'd1;
         d.cur = ips_lvl_t'(q.stack[d.depth]);
      end

      d.vec_addr = VEC_ADDR[best_idx];
      d.req_lvl = best_lvl;

      // Standby mode changes
      unique case (q.mode)
         MODE_RUN: begin
            if (i_hold_req) begin
               d.mode = MODE_HOLD;
            end else if (i_crystal_hold_mode_req) begin
               d.mode = MODE_CRYSTAL_HOLD_MODE;
               d.xtal_keep = i_xtal_osc_on;
            end else if (i_halt_req) begin
               d.mode = MODE_HALT;
            end
         end
         MODE_HALT: begin
            if (|vec_pend) begin
               d.mode = MODE_RUN;
            end
         end
         MODE_HOLD: begin
            if (wake_hold) begin
               d.mode = MODE_RUN;
            end
         end
         MODE_CRYSTAL_HOLD_MODE: begin
            if (wake_crystal_hold_mode) begin
               d.mode = MODE_RUN;
            end
         end
      endcase

      // Offer the winner only above the current level, never in standby
      d.irq_req = (best_lvl > d.cur) && !accept
         && (d.mode == MODE_RUN);

      // Clock and execution gating per mode
      d.cpu_run = (d.mode == MODE_RUN);
      d.periph_run = (d.mode == MODE_RUN)
         || (d.mode == MODE_HALT);
      d.main_osc = d.periph_run && i_main_osc_on;
      d.rc_osc = d.periph_run && i_rc_osc_on;
      unique case (d.mode)
         MODE_HOLD: d.xtal_osc = 1'b0;
         MODE_CRYSTAL_HOLD_MODE: d.xtal_osc = d.xtal_keep;
         default: d.xtal_osc = i_xtal_osc_on;
      endcase
      d.xtal_periph_run = d.periph_run
         || ((d.mode == MODE_CRYSTAL_HOLD_MODE) && d.xtal_keep);
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register, pin requests from the detector register
   assign o_irq_req = q.irq_req;
   assign o_irq_vec_addr = q.vec_addr;
   assign o_irq_level = q.req_lvl;
   assign o_stack_push = q.push;
   assign o_stack_bytes = q.push_bytes;
   assign o_mode = q.mode;
   assign o_cpu_run = q.cpu_run;
   assign o_periph_run = q.periph_run;
   assign o_xtal_periph_run = q.xtal_periph_run;
   assign o_main_osc_en = q.main_osc;
   assign o_rc_osc_en = q.rc_osc;
   assign o_xtal_osc_en = q.xtal_osc;
   assign o_vec_pend = q.pend;
   assign o_cur_level = q.cur;
   assign o_nest_depth = q.depth;
   assign o_ext_req = ext_req;
endmodule : ips_ctrl_top

//--- bench/ips_ctrl_sva.sv
// Port-level checks of the interrupt and standby controller
`timescale 1ns/1ps
module ips_ctrl_sva (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_irq_ack,
   input wire logic i_irq_ret,
   input wire logic o_irq_req,
   input wire ips_pkg::ips_lvl_t o_irq_level,
   input wire logic o_stack_push,
   input wire logic [3:0] o_stack_bytes,
   input wire ips_pkg::ips_mode_t o_mode,
   input wire logic o_cpu_run,
   input wire logic o_periph_run,
   input wire logic o_main_osc_en,
   input wire logic o_rc_osc_en,
   input wire logic o_xtal_osc_en,
   input wire logic [13:0] o_vec_pend,
   input wire ips_pkg::ips_lvl_t o_cur_level,
   input wire logic [1:0] o_nest_depth
);
   import ips_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_take;
      o_irq_req && i_irq_ack && o_cpu_run;
   endsequence
   sequence s_back;
      i_irq_ret && !i_irq_ack && o_nest_depth != 2'h0;
   endsequence
   push_bytes_a: assert property (s_take |=> o_stack_push &&
      o_stack_bytes == 4'h6) else $error("no push after accept");
   push_once_a: assert property (o_stack_push |=> !o_stack_push)
      else $error("push longer than one cycle");
   lvl_raise_a: assert property (s_take |=>
      o_cur_level == $past(o_irq_level) &&
      o_nest_depth == $past(o_nest_depth) + 2'h1)
      else $error("level not raised on accept");
   lvl_back_a: assert property (s_back |=>
      o_nest_depth == $past(o_nest_depth) - 2'h1)
      else $error("depth not restored on return");
   offer_above_a: assert property (o_irq_req |->
      o_irq_level > o_cur_level && o_mode == MODE_RUN)
      else $error("offer not above current level");
   hold_stop_a: assert property (o_mode == MODE_HOLD |-> !o_cpu_run &&
      !o_periph_run && !o_main_osc_en && !o_rc_osc_en && !o_xtal_osc_en)
      else $error("full hold left something running");
   crystal_hold_mode_keep_a: assert property (o_mode == MODE_CRYSTAL_HOLD_MODE &&
      $past(o_mode) == MODE_CRYSTAL_HOLD_MODE |-> $stable(o_xtal_osc_en) &&
      !o_main_osc_en && !o_rc_osc_en) else $error("crystal hold gating");
   wake_halt_a: assert property ($past(o_mode) == MODE_HALT &&
      |o_vec_pend |-> o_mode == MODE_RUN) else $error("halt not released");
endmodule : ips_ctrl_sva

bind ips_ctrl_top ips_ctrl_sva ips_ctrl_sva_inst (.i_ref_clk, .i_nrst,
   .i_irq_ack, .i_irq_ret, .o_irq_req, .o_irq_level, .o_stack_push,
   .o_stack_bytes, .o_mode, .o_cpu_run, .o_periph_run, .o_main_osc_en,
   .o_rc_osc_en, .o_xtal_osc_en, .o_vec_pend, .o_cur_level, .o_nest_depth);

//--- bench/ips_cpu_model.sv
// Behavioural CPU core that takes offered vectors after a delay
`timescale 1ns/1ps
module ips_cpu_model (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Controller side
   input wire logic i_irq_req,
   input wire logic i_cpu_run,
   // Test control
   input wire logic i_ack_en,
   input wire logic [3:0] i_dly,
   // Acknowledge pulse
   output logic o_irq_ack
);
   logic [3:0] wait_q;
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst || !i_irq_req || o_irq_ack) begin
         wait_q <= 4'h0;
         o_irq_ack <= 1'b0;
      end else begin
         wait_q <= wait_q + 4'h1;
         o_irq_ack <= i_ack_en && i_cpu_run && wait_q >= i_dly;
      end
   end
endmodule : ips_cpu_model

//--- bench/ips_ctrl_top_tb_top.sv
// Self-checking bench of the interrupt and standby controller
`timescale 1ns/1ps
module ips_ctrl_top_tb_top;
   import ips_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, ack_en = 1'b0, ret = 1'b0, ack;
   logic halt = 1'b0, hold = 1'b0, crystal_hold_mode = 1'b0, xon = 1'b1;
   logic [7:0] pin = 8'h00, rnd = 8'h3A, eclr = 8'h00;
   logic [5:0] p0 = 6'h00;
   logic [49:0] req = '0;
   logic [2:0] sel = 3'h0;
   ips_ext_mode_t emode [EXT_PINS] = '{default: EXT_HIGH};
   ips_lvl_t lvl [NUM_VEC] = '{default: LVL_NONE};
   logic irq, push, sclk, run, prun, xrun, mosc, rosc, xosc;
   logic [19:0] addr;
   logic [3:0] nbytes;
   logic [1:0] depth;
   logic [13:0] pend;
   logic [7:0] ereq;
   ips_lvl_t ilvl, cur;
   ips_mode_t mode;
   int fails = 0, n_tests = 0, cyc = 0;
   int sh [7] = '{5, 11, 40, 49, 52, 53, 63};
   logic [19:0] ad [7] = '{20'h0_8018, 20'h0_801C, 20'h0_803C, 20'h0_803C,
      20'h0_8018, 20'h0_801C, 20'h0_803C};

   ips_ctrl_top ips_ctrl_top_inst (.i_ref_clk(clk), .i_nrst(nrst),
      .i_ext_irq_pin(pin), .i_ext_mode(emode), .i_ext_clr(eclr),
      .i_port0_pin(p0), .i_port0_irq_en(6'h3F), .i_periph_req(req),
      .i_vec_level(lvl), .i_irq_ack(ack), .i_irq_ret(ret), .o_irq_req(irq),
      .o_irq_vec_addr(addr), .o_irq_level(ilvl), .o_stack_push(push),
      .o_stack_bytes(nbytes), .i_halt_req(halt), .i_hold_req(hold),
      .i_crystal_hold_mode_req(crystal_hold_mode), .i_main_osc_on(1'b1), .i_rc_osc_on(1'b1),
      .i_xtal_osc_on(xon), .o_mode(mode), .o_cpu_run(run),
      .o_periph_run(prun), .o_xtal_periph_run(xrun), .o_main_osc_en(mosc),
      .o_rc_osc_en(rosc), .o_xtal_osc_en(xosc), .i_clk_div_sel(sel),
      .o_sys_clk_en(sclk), .o_vec_pend(pend), .o_cur_level(cur),
      .o_nest_depth(depth), .o_ext_req(ereq));
   ips_cpu_model ips_cpu_model_inst (.i_ref_clk(clk), .i_nrst(nrst),
      .i_irq_req(irq), .i_cpu_run(run), .i_ack_en(ack_en), .i_dly(4'h2),
      .o_irq_ack(ack));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [19:0] e, g);
      #1;
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr
   function automatic int vof(input int i);
      int s;
      s = i < 40 ? i : i + 3;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (s >= VEC_FIRST[v] && s < VEC_FIRST[v+1]) return v;
      end
      return 0;
   endfunction : vof
   function automatic int win(input logic [49:0] r);
      int b;
      int v;
      b = -1;
      for (int i = 0; i < PERIPH_IN; i++) begin
         v = vof(i);
         if (r[i] && lvl[v] != LVL_NONE && (b < 0 || lvl[v] > lvl[b] ||
            (lvl[v] == lvl[b] && v < b))) b = v;
      end
      return b;
   endfunction : win
   task automatic stby(input logic [2:0] m, input logic [63:0] s,
      input ips_mode_t e);
      @(posedge clk) {halt, hold, crystal_hold_mode} <= m;
      @(posedge clk) {halt, hold, crystal_hold_mode} <= 3'h0;
      tick(1);
      chk("cpu_run", 20'h0, 20'(run));
      @(posedge clk) {p0, pin, req} <= s;
      tick(3);
      chk("mode", 20'(e), 20'(mode));
      @(posedge clk) {p0, pin, req} <= '0;
      tick(2);
   endtask : stby
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      int w;
      int n;
      tick(8);
      nrst <= 1'b1;
      tick(2);
      chk("bytes", 20'h0, 20'(nbytes));
      chk("level", 20'(LVL_NONE), 20'(cur));
      $display("reset test done");
      for (int t = 0; t < 40; t++) begin
         @(posedge clk);
         for (int v = 0; v < NUM_VEC; v++) begin
            rnd = lfsr(rnd);
            lvl[v] <= ips_lvl_t'(rnd[1:0]);
         end
         rnd = lfsr(rnd);
         n = rnd % PERIPH_IN;
         rnd = lfsr(rnd);
         req <= (50'h1 << n) | (50'h1 << (rnd % PERIPH_IN));
         tick(3);
         w = win(req);
         chk("offer", 20'(w >= 0), 20'(irq));
         if (w >= 0) chk("winner", VEC_ADDR[w], addr);
         @(posedge clk) req <= '0;
      end
      $display("arbitration test done");
      foreach (lvl[v]) lvl[v] <= LVL_LOW;
      for (int k = 0; k < 7; k++) begin
         @(posedge clk) {p0, pin, req} <= 64'h1 << sh[k];
         tick(3);
         chk("route", ad[k], addr);
         @(posedge clk) {p0, pin, req} <= '0;
         tick(2);
      end
      $display("routing test done");
      @(posedge clk) req <= 50'h1;
      lvl[2] <= LVL_HIGH;
      ack_en <= 1'b1;
      tick(6);
      chk("depth", 20'h1, 20'(depth));
      @(posedge clk) req <= 50'h21;
      tick(6);
      chk("depth", 20'h1, 20'(depth));
      @(posedge clk) req <= 50'h29;
      tick(6);
      chk("level", 20'(LVL_HIGH), 20'(cur));
      @(posedge clk) {req, ret} <= {50'h20, 1'b1};
      @(posedge clk) ret <= 1'b0;
      tick(1);
      chk("level", 20'(LVL_LOW), 20'(cur));
      @(posedge clk) ret <= 1'b1;
      @(posedge clk) ret <= 1'b0;
      tick(6);
      chk("depth", 20'h1, 20'(depth));
      @(posedge clk) {req, ret, ack_en} <= {50'h0, 2'b10};
      @(posedge clk) ret <= 1'b0;
      $display("nesting test done");
      stby(3'h2, 64'h2, MODE_HOLD);
      stby(3'h2, 64'h8 << 50, MODE_HOLD);
      stby(3'h2, 64'h1 << 37, MODE_RUN);
      stby(3'h1, 64'h2, MODE_RUN);
      stby(3'h4, 64'h1, MODE_RUN);
      // Crystal off at entry stays off even if software turns it on
      @(posedge clk) {xon, crystal_hold_mode} <= 2'b01;
      @(posedge clk) {xon, crystal_hold_mode} <= 2'b10;
      tick(1);
      chk("xtal_osc", 20'h0, 20'(xosc));
      chk("xtal_periph", 20'h0, 20'(xrun));
      @(posedge clk) req <= 50'h2;
      tick(2);
      chk("xtal_osc", 20'h1, 20'(xosc));
      chk("xtal_periph", 20'h1, 20'(xrun));
      @(posedge clk) req <= '0;
      // Rising edge request sticks until cleared
      @(posedge clk) begin
         emode[0] <= EXT_RISE;
         pin <= 8'h01;
      end
      @(posedge clk) pin <= 8'h00;
      tick(2);
      chk("edge_req", 20'h1, 20'(ereq[0]));
      @(posedge clk) eclr <= 8'h01;
      @(posedge clk) eclr <= 8'h00;
      tick(1);
      chk("edge_req", 20'h0, 20'(ereq[0]));
      $display("standby test done");
      for (int k = 0; k < 8; k++) begin
         @(posedge clk) sel <= 3'(k);
         tick(130);
         #1;
         // Sample the enable settled, off the launching edge
         while (sclk !== 1'b1) @(posedge clk) #1;
         n = 0;
         do begin
            @(posedge clk) #1;
            n++;
         end while (sclk !== 1'b1);
         chk("divide", 20'(1 << k), 20'(n));
      end
      $display("divider test done");
      tally_and_finish();
   end
endmodule : ips_ctrl_top_tb_top
